// ### verilog/port_pin_data_pkg.sv
// constants and carrier types of the lower port pin mux
package port_pin_data_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_PIN_DATA = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_LATCH = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_DIR = 2'h2;
    // ----------------------------------------
    // reset values and bit positions
    // ----------------------------------------
    localparam logic [DATA_W-1:0] DIR_RST = 8'hff;
    localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam int BIT_TIMER1_OSC_OUT = 0;
    localparam int BIT_TIMER1_OSC_IN = 1;
    localparam int BIT_CAPCMP2 = 1;
    localparam int BIT_ECAPCMP = 2;
    localparam int BIT_SPI_CLK = 3;
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic timer1_osc_en;
        logic capcmp2_pin_select;
        logic capcmp2_out_en;
        logic capcmp2_out;
        logic ecapcmp_out_en;
        logic ecapcmp_out;
        logic pwm_a_en;
        logic pwm_a;
        logic pwm_shutdown;
        logic pwm_shutdown_tristate;
        logic spi_clk_out_en;
        logic spi_clk_out;
    } periph_ctrl_s;
    typedef struct packed {
        logic timer13_count_clock_in;
        logic capcmp2_capture_in;
        logic ecapcmp_capture_in;
        logic spi_clk_in;
    } periph_in_s;
endpackage : port_pin_data_pkg

// ### verilog/port_c_pin_mux_lower.sv
// lower port pin multiplexer with direction, latch and pin registers
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module port_c_pin_mux_lower (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [port_pin_data_pkg::ADDR_W-1:0] addr,
    input wire logic [port_pin_data_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [port_pin_data_pkg::DATA_W-1:0] rdata,
    input wire logic [port_pin_data_pkg::DATA_W-1:0] pin_in,
    output logic [port_pin_data_pkg::DATA_W-1:0] pin_out,
    output logic [port_pin_data_pkg::DATA_W-1:0] pin_oe,
    output logic timer1_osc_active,
    input wire port_pin_data_pkg::periph_ctrl_s periph_ctrl,
    output port_pin_data_pkg::periph_in_s periph_in
);
    import port_pin_data_pkg::*;

    // ----------------------------------------
    // reset release and pin sampling
    // ----------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [DATA_W-1:0] pin_meta_r;
    logic [DATA_W-1:0] pin_sync_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // two-flop pin sampler; only the second stage is read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= ZERO_BYTE;
            pin_sync_r <= ZERO_BYTE;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [DATA_W-1:0] dir_r;
    logic [DATA_W-1:0] latch_r;
    logic [DATA_W-1:0] pin_view;
    logic wr_latch;

    // both the pin data and latch addresses write the latch
    assign wr_latch = wr && (addr == ADDR_PIN_DATA || addr == ADDR_LATCH);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_r <= DIR_RST;
        end else if (wr && addr == ADDR_DIR) begin
            dir_r <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r <= LATCH_RST;
        end else if (wr_latch) begin
            latch_r <= wdata;
        end
    end

    // oscillator pins have digital input disabled
    always_comb begin
        pin_view = pin_sync_r;
        if (periph_ctrl.timer1_osc_en) begin
            pin_view[BIT_TIMER1_OSC_OUT] = 1'b0;
            pin_view[BIT_TIMER1_OSC_IN] = 1'b0;
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= ZERO_BYTE;
        end else if (rd) begin
            case (addr)
                ADDR_PIN_DATA: rdata <= pin_view;
                ADDR_LATCH: rdata <= latch_r;
                ADDR_DIR: rdata <= dir_r;
                default: rdata <= ZERO_BYTE;
            endcase
        end else begin
            rdata <= ZERO_BYTE;
        end
    end

    // ----------------------------------------
    // pin driver mux
    // ----------------------------------------
    logic [DATA_W-1:0] out_nxt;
    logic [DATA_W-1:0] oe_nxt;
    logic c2_here;

    assign c2_here = periph_ctrl.capcmp2_pin_select;

    always_comb begin
        out_nxt = latch_r;
        oe_nxt = ~dir_r;
        if (c2_here && periph_ctrl.capcmp2_out_en && !dir_r[BIT_CAPCMP2]) begin
            out_nxt[BIT_CAPCMP2] = periph_ctrl.capcmp2_out;
        end
        if (periph_ctrl.ecapcmp_out_en && !dir_r[BIT_ECAPCMP]) begin
            out_nxt[BIT_ECAPCMP] = periph_ctrl.ecapcmp_out;
        end
        if (periph_ctrl.pwm_a_en) begin
            out_nxt[BIT_ECAPCMP] = periph_ctrl.pwm_a;
            oe_nxt[BIT_ECAPCMP] = 1'b1;
            if (periph_ctrl.pwm_shutdown && periph_ctrl.pwm_shutdown_tristate) begin
                oe_nxt[BIT_ECAPCMP] = 1'b0;
            end
        end
        if (periph_ctrl.spi_clk_out_en && !dir_r[BIT_SPI_CLK]) begin
            out_nxt[BIT_SPI_CLK] = periph_ctrl.spi_clk_out;
        end
        if (periph_ctrl.timer1_osc_en) begin
            out_nxt[BIT_TIMER1_OSC_OUT] = 1'b0;
            out_nxt[BIT_TIMER1_OSC_IN] = 1'b0;
            oe_nxt[BIT_TIMER1_OSC_OUT] = 1'b0;
            oe_nxt[BIT_TIMER1_OSC_IN] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= ZERO_BYTE;
            pin_oe <= ZERO_BYTE;
            timer1_osc_active <= 1'b0;
        end else begin
            pin_out <= out_nxt;
            pin_oe <= oe_nxt;
            timer1_osc_active <= periph_ctrl.timer1_osc_en;
        end
    end

    // ----------------------------------------
    // peripheral inputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_in <= '0;
        end else begin
            periph_in.timer13_count_clock_in <= dir_r[BIT_TIMER1_OSC_OUT] && pin_view[BIT_TIMER1_OSC_OUT];
            periph_in.capcmp2_capture_in <= c2_here && dir_r[BIT_CAPCMP2] && pin_view[BIT_CAPCMP2];
            periph_in.ecapcmp_capture_in <= dir_r[BIT_ECAPCMP] && pin_view[BIT_ECAPCMP];
            periph_in.spi_clk_in <= dir_r[BIT_SPI_CLK] && pin_view[BIT_SPI_CLK];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_dir_input_hiz: assert property (
        (dir_r[7] && wr == 1'b0) |=> !pin_oe[7])
        else $error("upper pin driven while direction is input");

    a_latch_drives_pin: assert property (
        (!dir_r[5]) |=> (pin_oe[5] && pin_out[5] == $past(latch_r[5])))
        else $error("output pin does not follow latch");

    a_latch_readback: assert property (
        (wr && addr == ADDR_LATCH) ##1 (rd && addr == ADDR_LATCH && !wr) |=> rdata == $past(wdata, 2))
        else $error("latch read does not return written value");

    a_dir_readback: assert property (
        (rd && addr == ADDR_DIR) |=> rdata == $past(dir_r))
        else $error("direction read differs from stored bits");

    a_osc_disables_io: assert property (
        periph_ctrl.timer1_osc_en |=> (pin_oe[1:0] == 2'h0 && timer1_osc_active))
        else $error("oscillator pins still driven");

    a_capcmp2_priority: assert property (
        (c2_here && periph_ctrl.capcmp2_out_en && !dir_r[1] && !periph_ctrl.timer1_osc_en)
        |=> (pin_oe[1] && pin_out[1] == $past(periph_ctrl.capcmp2_out)))
        else $error("compare output lost on bit 1");

    a_capcmp2_alt_pin: assert property (
        !c2_here |=> !periph_in.capcmp2_capture_in)
        else $error("capture fed while unit sits on alternate pin");

    a_pwm_shutdown_hiz: assert property (
        (periph_ctrl.pwm_a_en && periph_ctrl.pwm_shutdown && periph_ctrl.pwm_shutdown_tristate)
        |=> !pin_oe[2])
        else $error("pwm channel a driven during shutdown");

    a_spi_clk_input: assert property (
        (dir_r[3] && pin_sync_r[3]) |=> periph_in.spi_clk_in)
        else $error("spi clock input not passed");

    a_pin_read_sync: assert property (
        (rd && addr == ADDR_PIN_DATA && !periph_ctrl.timer1_osc_en) |=> rdata == $past(pin_sync_r))
        else $error("pin data read is not sampled pin level");

    // ----------------------------------------
    // checks of reset, register writes and reads, pin drivers and peripheral inputs
    // ----------------------------------------
    a_reset_all_inputs: assert property (
        $rose(rst_n) |-> (pin_oe == ZERO_BYTE && dir_r == DIR_RST && latch_r == LATCH_RST
            && periph_in == '0 && rdata == ZERO_BYTE && !timer1_osc_active))
        else $error("port not idle as inputs after reset");

    a_upper_dir_map: assert property (
        1'b1 |=> pin_oe[7:4] == ~$past(dir_r[7:4]))
        else $error("upper pin enables do not follow direction bits");

    a_upper_latch_map: assert property (
        1'b1 |=> pin_out[7:4] == $past(latch_r[7:4]))
        else $error("upper pin values do not follow latch");

    a_dir_write: assert property (
        (wr && addr == ADDR_DIR) |=> dir_r == $past(wdata))
        else $error("direction write not stored");

    a_pin_data_write: assert property (
        (wr && addr == ADDR_PIN_DATA) |=> latch_r == $past(wdata))
        else $error("pin data write did not reach latch");

    a_unmapped_read: assert property (
        (rd && addr != ADDR_PIN_DATA && addr != ADDR_LATCH && addr != ADDR_DIR) |=> rdata == ZERO_BYTE)
        else $error("unmapped read returned data");

    a_read_idle_zero: assert property (
        !rd |=> rdata == ZERO_BYTE)
        else $error("read data stands beyond one cycle");

    a_ecapcmp_priority: assert property (
        (periph_ctrl.ecapcmp_out_en && !dir_r[2] && !periph_ctrl.pwm_a_en)
        |=> (pin_oe[2] && pin_out[2] == $past(periph_ctrl.ecapcmp_out)))
        else $error("enhanced compare output lost on bit 2");

    a_pwm_a_drives: assert property (
        (periph_ctrl.pwm_a_en && !(periph_ctrl.pwm_shutdown && periph_ctrl.pwm_shutdown_tristate))
        |=> (pin_oe[2] && pin_out[2] == $past(periph_ctrl.pwm_a)))
        else $error("pwm channel a not on bit 2");

    a_spi_clk_priority: assert property (
        (periph_ctrl.spi_clk_out_en && !dir_r[3])
        |=> (pin_oe[3] && pin_out[3] == $past(periph_ctrl.spi_clk_out)))
        else $error("spi clock output lost on bit 3");

    a_ecapcmp_capture: assert property (
        dir_r[2] |=> periph_in.ecapcmp_capture_in == $past(pin_sync_r[2]))
        else $error("enhanced capture input not passed");

    a_capcmp2_capture: assert property (
        (c2_here && dir_r[1] && !periph_ctrl.timer1_osc_en)
        |=> periph_in.capcmp2_capture_in == $past(pin_sync_r[1]))
        else $error("capture input on bit 1 not passed");

    a_count_clock_in: assert property (
        (dir_r[0] && !periph_ctrl.timer1_osc_en) |=> periph_in.timer13_count_clock_in == $past(pin_sync_r[0]))
        else $error("counter clock input not passed");

    a_osc_blocks_inputs: assert property (
        periph_ctrl.timer1_osc_en |=> (!periph_in.timer13_count_clock_in && !periph_in.capcmp2_capture_in))
        else $error("oscillator pins still feed peripherals");

    a_output_no_capture: assert property (
        (!dir_r[3] && !dir_r[2]) |=> (!periph_in.spi_clk_in && !periph_in.ecapcmp_capture_in))
        else $error("output pins feed peripheral inputs");

    a_dir_kept_override: assert property (
        (!wr && periph_ctrl.pwm_a_en) |=> dir_r == $past(dir_r))
        else $error("override changed stored direction");

    a_osc_reads_zero: assert property (
        (rd && addr == ADDR_PIN_DATA && periph_ctrl.timer1_osc_en) |=> rdata[1:0] == 2'h0)
        else $error("oscillator pins read as digital levels");
endmodule : port_c_pin_mux_lower

// ### sim/pin_board_model.sv
// board side of the port pins: resolves each wire from both drivers
`timescale 1ns/1ps
module pin_board_model (
    input wire logic [port_pin_data_pkg::DATA_W-1:0] pin_out,
    input wire logic [port_pin_data_pkg::DATA_W-1:0] pin_oe,
    input wire logic [port_pin_data_pkg::DATA_W-1:0] ext_drive,
    output logic [port_pin_data_pkg::DATA_W-1:0] pin_in
);
    import port_pin_data_pkg::*;
    // board drives only where the port driver is off
    assign pin_in = (pin_out & pin_oe) | (ext_drive & ~pin_oe);
endmodule : pin_board_model

// ### sim/port_c_pin_mux_lower_bench.sv
// self-checking bench of the lower port pin mux
`timescale 1ns/1ps
module port_c_pin_mux_lower_bench;
    import port_pin_data_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, t1a;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, pin_in, pin_out, pin_oe, ext = '0, d, l, e, pins;
    logic [15:0] dr;
    periph_ctrl_s periph_ctrl = '0, p;
    periph_in_s periph_in, ei;
    int n_mismatch = 0, comparisons = 0;
    port_c_pin_mux_lower port_c_pin_mux_lower_inst (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .timer1_osc_active(t1a), .periph_ctrl(periph_ctrl), .periph_in(periph_in));
    pin_board_model pin_board_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext), .pin_in(pin_in));
    initial begin
        forever #10 clk = ~clk;
    end
    // ----------------------------------------
    // bus tasks and comparisons
    // ----------------------------------------
    task automatic conclude();
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t port output %h expected %h", $time, got, exp);
        end
    endtask : chk_pin
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t read at %0d gave %h expected %h", $time, a, got, exp);
        end
    endtask : chk_rd
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk_rd(a, rdata, exp);
    endtask : rd_chk
    // write then read the same address with no gap
    task automatic wr_rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk_rd(a, rdata, v);
    endtask : wr_rd_chk
    // expected {enable, value} of the port drivers
    function automatic logic [15:0] drive_of(logic [7:0] d, logic [7:0] l, periph_ctrl_s p);
        logic [7:0] oe, o;
        oe = ~d;
        o = l;
        if (p.capcmp2_pin_select && p.capcmp2_out_en && !d[1]) o[1] = p.capcmp2_out;
        if (p.ecapcmp_out_en && !d[2]) o[2] = p.ecapcmp_out;
        if (p.pwm_a_en) begin
            oe[2] = !(p.pwm_shutdown && p.pwm_shutdown_tristate);
            o[2] = p.pwm_a;
        end
        if (p.spi_clk_out_en && !d[3]) o[3] = p.spi_clk_out;
        if (p.timer1_osc_en) oe[1:0] = 2'h0;
        return {oe, o};
    endfunction : drive_of
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        void'($urandom(34544));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_pin(pin_oe, 8'h00);
        rd_chk(ADDR_DIR, 8'hff);
        wr_reg(ADDR_LATCH, 8'ha5);
        rd_chk(ADDR_LATCH, 8'ha5);
        wr_rd_chk(ADDR_LATCH, 8'h5a);
        repeat (150) begin
            d = 8'($urandom);
            l = 8'($urandom);
            e = 8'($urandom);
            p = periph_ctrl_s'(12'($urandom));
            wr_reg(ADDR_DIR, d);
            wr_reg(($urandom % 2) ? ADDR_LATCH : ADDR_PIN_DATA, l);
            wr_reg(2'h3, 8'($urandom));
            @(posedge clk);
            periph_ctrl <= p;
            ext <= e;
            repeat (5) @(posedge clk);
            @(negedge clk);
            dr = drive_of(d, l, p);
            pins = (dr[7:0] & dr[15:8]) | (e & ~dr[15:8]);
            ei.timer13_count_clock_in = d[0] & pins[0] & !p.timer1_osc_en;
            ei.capcmp2_capture_in = d[1] & pins[1] & p.capcmp2_pin_select & !p.timer1_osc_en;
            ei.ecapcmp_capture_in = d[2] & pins[2];
            ei.spi_clk_in = d[3] & pins[3];
            chk_pin(pin_oe, dr[15:8]);
            chk_pin(pin_out & dr[15:8], dr[7:0] & dr[15:8]);
            chk_pin({4'h0, periph_in}, {4'h0, ei});
            chk_pin({7'h0, t1a}, {7'h0, p.timer1_osc_en});
            rd_chk(ADDR_DIR, d);
            rd_chk(ADDR_LATCH, l);
            rd_chk(ADDR_PIN_DATA, pins & (p.timer1_osc_en ? 8'hfc : 8'hff));
            rd_chk(2'h3, 8'h00);
        end
        // reset in mid-run: pins back to inputs, registers to reset values
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_pin(pin_oe, 8'h00);
        chk_pin({4'h0, periph_in}, 8'h00);
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(ADDR_DIR, DIR_RST);
        rd_chk(ADDR_LATCH, LATCH_RST);
        conclude();
    end
    // watchdog: several times the expected length of the run
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
endmodule : port_c_pin_mux_lower_bench
